/* ubc_pkg.sv */
// Purpose: shared constants of the two-channel user break comparator
// Assumes: bus-cycle select word laid out as below
// Notes: trigger widths are counted in core clock cycles
package ubc_pkg;
  // bus-cycle select field positions
  localparam int BBR_SZ_LSB = 0;
  localparam int BBR_RW_LSB = 2;
  localparam int BBR_ID_LSB = 4;
  localparam int BBR_CD_LSB = 6;
  localparam int BBR_DATA_EN = 12;
  localparam int BBR_SUPPRESS = 13;
  // bit inside a two-bit select pair
  localparam int SEL_FIRST = 0;
  localparam int SEL_SECOND = 1;
  // bus select codes
  localparam logic [1:0] BUS_NONE = 2'h0;
  localparam logic [1:0] BUS_C = 2'h1;
  localparam logic [1:0] BUS_I = 2'h2;
  localparam logic [1:0] BUS_BOTH = 2'h3;
  // operand size codes
  localparam logic [1:0] SZ_ANY = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;
  // match flag positions
  localparam int FLG_C0 = 0;
  localparam int FLG_C1 = 1;
  localparam int FLG_I0 = 2;
  localparam int FLG_I1 = 3;
  // reset values
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [3:0] CNT_RST = 4'h0;
  // trigger pulse lengths per width code
  localparam logic [3:0] TRIG_LEN_0 = 4'h1;
  localparam logic [3:0] TRIG_LEN_1 = 4'h2;
  localparam logic [3:0] TRIG_LEN_2 = 4'h4;
  localparam logic [3:0] TRIG_LEN_3 = 4'h8;
endpackage

/* chan_if.sv */
// Purpose: carries settings and bus cycles to one comparator channel
// Assumes: one instance per channel
// Notes: hit outputs are combinational
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  logic [31:0] bar;
  logic [31:0] break_address_mask_reg;
  logic [31:0] break_data_reg;
  logic [31:0] break_data_mask_reg;
  logic [15:0] bus_cycle_select_reg;
  logic f_valid;
  logic [31:0] f_addr;
  logic c_valid;
  logic [31:0] c_addr;
  logic [31:0] c_data;
  logic c_write;
  logic [1:0] c_size;
  logic c_prefetch_instruction;
  logic i_valid;
  logic [31:0] i_addr;
  logic [31:0] i_data;
  logic i_write;
  logic [1:0] i_size;
  logic f_hit;
  logic c_hit;
  logic i_hit;
  modport cmp(
    input bar, break_address_mask_reg, break_data_reg, break_data_mask_reg, bus_cycle_select_reg, f_valid, f_addr,
    input c_valid, c_addr, c_data, c_write, c_size, c_prefetch_instruction,
    input i_valid, i_addr, i_data, i_write, i_size,
    output f_hit, c_hit, i_hit
  );
  modport ctl(
    output bar, break_address_mask_reg, break_data_reg, break_data_mask_reg, bus_cycle_select_reg, f_valid, f_addr,
    output c_valid, c_addr, c_data, c_write, c_size, c_prefetch_instruction,
    output i_valid, i_addr, i_data, i_write, i_size,
    input f_hit, c_hit, i_hit
  );
endinterface
`default_nettype wire

/* break_channel.sv */
// Purpose: address, data and bus-cycle comparison of one channel
// Assumes: cycle strobes are single-cycle and confirmed
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module break_channel (
  // settings and cycles in, hits out
  chan_if.cmp ch
);
  logic [1:0] cd;
  logic [1:0] id;
  logic [1:0] rw;
  logic [1:0] sz;
  logic den;
  logic cfg_ok;

  // masked compare: a one in the mask drops the bit
  function automatic logic masked_eq(input logic [31:0] a,
                                     input logic [31:0] b,
                                     input logic [31:0] m);
    return ((a ^ b) & ~m) == 32'h0000_0000;
  endfunction

  // one data-access cycle against this channel
  function automatic logic access_hit(input logic v,
                                      input logic [31:0] a,
                                      input logic [31:0] d,
                                      input logic w,
                                      input logic [1:0] s,
                                      input logic nodata);
    logic [31:0] ign;
    logic rw_ok;
    logic sz_ok;
    logic d_ok;
    ign = ch.break_address_mask_reg;
    if (s == ubc_pkg::SZ_LONG) begin
      ign[1:0] = 2'h3;
    end else if (s == ubc_pkg::SZ_WORD) begin
      ign[0] = 1'b1;
    end
    rw_ok = w ? rw[ubc_pkg::SEL_SECOND] : rw[ubc_pkg::SEL_FIRST];
    sz_ok = (sz == ubc_pkg::SZ_ANY && !den) || (sz == s);
    d_ok = !den || (!nodata && masked_eq(d, ch.break_data_reg, ch.break_data_mask_reg));
    return v && rw_ok && sz_ok && d_ok && masked_eq(a, ch.bar, ign);
  endfunction

  always_comb begin
    cd = ch.bus_cycle_select_reg[ubc_pkg::BBR_CD_LSB +: 2];
    id = ch.bus_cycle_select_reg[ubc_pkg::BBR_ID_LSB +: 2];
    rw = ch.bus_cycle_select_reg[ubc_pkg::BBR_RW_LSB +: 2];
    sz = ch.bus_cycle_select_reg[ubc_pkg::BBR_SZ_LSB +: 2];
    den = ch.bus_cycle_select_reg[ubc_pkg::BBR_DATA_EN];
    // bus, id or rw pair at 00 or both buses: never
    cfg_ok = (cd != ubc_pkg::BUS_NONE) && (id != 2'h0) && (rw != 2'h0)
             && (cd != ubc_pkg::BUS_BOTH);
    // fetch: c bus, read, not byte, lsb clear, data ignored
    ch.f_hit = cfg_ok && (cd == ubc_pkg::BUS_C)
               && id[ubc_pkg::SEL_FIRST] && rw[ubc_pkg::SEL_FIRST]
               && (sz != ubc_pkg::SZ_BYTE)
               && !ch.bar[0]
               && ch.f_valid
               && masked_eq(ch.f_addr, ch.bar, ch.break_address_mask_reg);
    // prefetch counts as a longword read without data
    ch.c_hit = cfg_ok && (cd == ubc_pkg::BUS_C) && id[ubc_pkg::SEL_SECOND]
               && access_hit(ch.c_valid, ch.c_addr, ch.c_data,
                             ch.c_write && !ch.c_prefetch_instruction,
                             ch.c_prefetch_instruction ? ubc_pkg::SZ_LONG : ch.c_size,
                             ch.c_prefetch_instruction);
    ch.i_hit = cfg_ok && (cd == ubc_pkg::BUS_I) && id[ubc_pkg::SEL_SECOND]
               && access_hit(ch.i_valid, ch.i_addr, ch.i_data,
                             ch.i_write, ch.i_size, 1'b0);
  end
endmodule // break_channel
`default_nettype wire

/* user_break_unit.sv */
// Purpose: two-channel user break unit with request and trigger output
// Assumes: core reports confirmed instructions, branch targets, accesses
// Notes: settings are plain ports; flags cleared by a write strobe
//
// Overview of operation
// - c bus fetch read settings of any size but byte compare fetch addresses
// - per-channel select picks break before or after execution
// - fetch break with address lsb set never fires
// - only instructions confirmed to execute can break
// - delay slot matches and post-execution delayed branch matches wait for branch target
// - post-execution break fires before the next instruction executes
// - break data is ignored for instruction fetch channels
// - i bus with instruction fetch gives no break
// - c bus compares executed accesses, i bus its access cycles
// - longword ignores two low address bits, word one, byte none
// - data condition needs a size and both address and data match
// - prefetch is a longword read without data, never data-matches
// - pre-execution saves matched address, delay slot saves target
// - post-execution saves next address, or target for branch pairs
// - data breaks return some instructions after the access
// - a channel watches either c bus or i bus, never both
// - a higher-priority exception at the same instruction drops it
// - module standby gives no breaks; software leaves settings alone
// - pre-execution break on lower halfword acts as post-execution
// - a match requests once unless its suppress bit is set, sets its flag, pulses the trigger
// - a bus, id or rw select pair at 00 disables the channel
// - writing 0 clears a match flag, writing 1 keeps it
// - simultaneous channel matches give one request, both flags
`timescale 1ns/1ps
`default_nettype none
module user_break_unit (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,

  // channel 0 settings
  input wire logic [31:0] ch0_break_address,
  input wire logic [31:0] ch0_break_address_mask_reg,
  input wire logic [31:0] ch0_break_data_reg,
  input wire logic [31:0] ch0_break_data_mask_reg,
  input wire logic [15:0] ch0_bus_cycle_select_reg,

  // channel 1 settings
  input wire logic [31:0] ch1_break_address,
  input wire logic [31:0] ch1_break_address_mask_reg,
  input wire logic [31:0] ch1_break_data_reg,
  input wire logic [31:0] ch1_break_data_mask_reg,
  input wire logic [15:0] ch1_bus_cycle_select_reg,

  // break control settings
  input wire logic ch0_post_exec_select,
  input wire logic ch1_post_exec_select,
  input wire logic [1:0] trigger_pulse_width,
  input wire logic module_standby,

  // match flag clear strobe
  input wire logic flag_write,
  input wire logic [3:0] flag_write_data,

  // confirmed instruction stream
  input wire logic exec_valid,
  input wire logic [31:0] exec_addr,
  input wire logic exec_delay_slot,
  input wire logic exec_delayed_branch,
  input wire logic exec_lower_half,
  input wire logic target_valid,
  input wire logic [31:0] target_addr,
  input wire logic higher_exception,

  // c bus data access
  input wire logic cbus_valid,
  input wire logic [31:0] cbus_addr,
  input wire logic [31:0] cbus_data,
  input wire logic cbus_write,
  input wire logic [1:0] cbus_size,
  input wire logic prefetch_instruction,

  // i bus data access
  input wire logic ibus_valid,
  input wire logic [31:0] ibus_addr,
  input wire logic [31:0] ibus_data,
  input wire logic ibus_write,
  input wire logic [1:0] ibus_size,

  // results
  output logic break_request,
  output logic [31:0] break_return_addr,
  output logic break_trigger_out_n,
  output logic [1:0] cbus_match_flag,
  output logic [1:0] ibus_match_flag
);

  typedef struct packed {
    logic [3:0] flags;
    logic req;
    logic trig_n;
    logic [3:0] trig_cnt;
    logic pend_next;
    logic pend_tgt;
    logic [1:0] pend_ch;
    logic [31:0] ret_addr;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [1:0] post_sel;
  logic [1:0] suppress;

  logic [1:0] f_hit;
  logic [1:0] c_hit;
  logic [1:0] i_hit;

  logic [1:0] pre_hit;
  logic [1:0] post_hit;

  logic [1:0] now_ch;
  logic [1:0] tgt_ch;
  logic [1:0] next_ch;
  logic [1:0] fire_ch;
  logic [31:0] fire_addr;
  logic fire;

  logic [3:0] set_flags;
  logic [3:0] clr_flags;

  chan_if cb0 ();
  chan_if cb1 ();

  // trigger length per width code
  function automatic logic [3:0] trig_len(input logic [1:0] code);
    logic [3:0] len;
    len = ubc_pkg::TRIG_LEN_0;
    if (code == 2'h1) begin
      len = ubc_pkg::TRIG_LEN_1;
    end else if (code == 2'h2) begin
      len = ubc_pkg::TRIG_LEN_2;
    end else if (code == 2'h3) begin
      len = ubc_pkg::TRIG_LEN_3;
    end
    return len;
  endfunction

  // channel 0 settings and cycles
  assign cb0.bar = ch0_break_address;
  assign cb0.break_address_mask_reg = ch0_break_address_mask_reg;

  assign cb0.break_data_reg = ch0_break_data_reg;
  assign cb0.break_data_mask_reg = ch0_break_data_mask_reg;

  assign cb0.bus_cycle_select_reg = ch0_bus_cycle_select_reg;

  assign cb0.f_valid = exec_valid && !module_standby;
  assign cb0.f_addr = exec_addr;

  assign cb0.c_valid = cbus_valid && !module_standby;
  assign cb0.c_addr = cbus_addr;
  assign cb0.c_data = cbus_data;
  assign cb0.c_write = cbus_write;
  assign cb0.c_size = cbus_size;
  assign cb0.c_prefetch_instruction = prefetch_instruction;

  assign cb0.i_valid = ibus_valid && !module_standby;
  assign cb0.i_addr = ibus_addr;
  assign cb0.i_data = ibus_data;
  assign cb0.i_write = ibus_write;
  assign cb0.i_size = ibus_size;

  // channel 1 settings and cycles
  assign cb1.bar = ch1_break_address;
  assign cb1.break_address_mask_reg = ch1_break_address_mask_reg;

  assign cb1.break_data_reg = ch1_break_data_reg;
  assign cb1.break_data_mask_reg = ch1_break_data_mask_reg;

  assign cb1.bus_cycle_select_reg = ch1_bus_cycle_select_reg;

  assign cb1.f_valid = exec_valid && !module_standby;
  assign cb1.f_addr = exec_addr;

  assign cb1.c_valid = cbus_valid && !module_standby;
  assign cb1.c_addr = cbus_addr;
  assign cb1.c_data = cbus_data;
  assign cb1.c_write = cbus_write;
  assign cb1.c_size = cbus_size;
  assign cb1.c_prefetch_instruction = prefetch_instruction;

  assign cb1.i_valid = ibus_valid && !module_standby;
  assign cb1.i_addr = ibus_addr;
  assign cb1.i_data = ibus_data;
  assign cb1.i_write = ibus_write;
  assign cb1.i_size = ibus_size;

  break_channel u_ch0 (
    .ch(cb0.cmp)
  );

  break_channel u_ch1 (
    .ch(cb1.cmp)
  );

  always_comb begin
    post_sel = {ch1_post_exec_select, ch0_post_exec_select};
    suppress = {ch1_bus_cycle_select_reg[ubc_pkg::BBR_SUPPRESS],
                ch0_bus_cycle_select_reg[ubc_pkg::BBR_SUPPRESS]};

    f_hit = {cb1.f_hit, cb0.f_hit};
    c_hit = {cb1.c_hit, cb0.c_hit};
    i_hit = {cb1.i_hit, cb0.i_hit};

    // lower halfword of a long instruction breaks after execution
    pre_hit = f_hit & ~post_sel & {2{!exec_lower_half}};
    post_hit = f_hit & (post_sel | {2{exec_lower_half}});
  end

  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    now_ch = 2'h0;
    tgt_ch = 2'h0;
    next_ch = 2'h0;
    fire_ch = 2'h0;
    fire_addr = s_q.ret_addr;
    fire = 1'b0;

    // sort new matches by when they must be taken
    if (exec_delay_slot) begin
      tgt_ch = pre_hit;
    end else begin
      now_ch = pre_hit;
    end

    if (exec_delay_slot || exec_delayed_branch) begin
      tgt_ch = tgt_ch | post_hit;
    end else begin
      next_ch = post_hit;
    end

    next_ch = next_ch | c_hit | i_hit;

    // release earlier pending matches
    if (s_q.pend_tgt && target_valid) begin
      fire = 1'b1;
      fire_ch = s_q.pend_ch;
      fire_addr = target_addr;
      s_d.pend_tgt = 1'b0;
      s_d.pend_ch = 2'h0;
    end else if (s_q.pend_next && exec_valid) begin
      fire = 1'b1;
      fire_ch = s_q.pend_ch;
      fire_addr = exec_addr;
      s_d.pend_next = 1'b0;
      s_d.pend_ch = 2'h0;
    end

    // a pre-execution hit fires at once with its own address
    if (now_ch != 2'h0) begin
      fire = 1'b1;
      fire_ch = fire_ch | now_ch;
      fire_addr = exec_addr;
    end

    // park new deferred matches; a target wait wins over next
    if (tgt_ch != 2'h0) begin
      s_d.pend_tgt = 1'b1;
      s_d.pend_next = 1'b0;
      s_d.pend_ch = s_d.pend_ch | tgt_ch;
    end else if (next_ch != 2'h0 && !s_d.pend_tgt) begin
      s_d.pend_next = 1'b1;
      s_d.pend_ch = s_d.pend_ch | next_ch;
    end else if (next_ch != 2'h0) begin
      s_d.pend_ch = s_d.pend_ch | next_ch;
    end

    // standby stops any release
    if (module_standby) begin
      fire = 1'b0;
    end

    // one request for all firing channels unless suppressed
    if (fire && !higher_exception) begin
      s_d.req = |(fire_ch & ~suppress);
      s_d.ret_addr = fire_addr;
    end

    if (fire && higher_exception) begin
      s_d.req = 1'b0;
    end

    // trigger pulse for the programmed width
    if (fire) begin
      s_d.trig_cnt = trig_len(trigger_pulse_width);
      s_d.trig_n = 1'b0;
    end else if (s_q.trig_cnt > 4'h1) begin
      s_d.trig_cnt = s_q.trig_cnt - 4'h1;
    end else begin
      s_d.trig_cnt = ubc_pkg::CNT_RST;
      s_d.trig_n = 1'b1;
    end

    // standby drops everything pending and holds the request low
    if (module_standby) begin
      s_d.pend_tgt = 1'b0;
      s_d.pend_next = 1'b0;
      s_d.pend_ch = 2'h0;
      s_d.req = 1'b0;
    end

    // flags set at match time; a set beats a same-cycle clear
    set_flags = 4'h0;
    set_flags[ubc_pkg::FLG_C0] = f_hit[0] || c_hit[0];
    set_flags[ubc_pkg::FLG_C1] = f_hit[1] || c_hit[1];
    set_flags[ubc_pkg::FLG_I0] = i_hit[0];
    set_flags[ubc_pkg::FLG_I1] = i_hit[1];

    clr_flags = flag_write ? ~flag_write_data : 4'h0;
    s_d.flags = (s_q.flags & ~clr_flags) | set_flags;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q.flags <= ubc_pkg::FLAGS_RST;
      s_q.req <= 1'b0;
      s_q.trig_n <= 1'b1;
      s_q.trig_cnt <= ubc_pkg::CNT_RST;
      s_q.pend_next <= 1'b0;
      s_q.pend_tgt <= 1'b0;
      s_q.pend_ch <= 2'h0;
      s_q.ret_addr <= ubc_pkg::ADDR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign break_request = s_q.req;
  assign break_return_addr = s_q.ret_addr;
  assign break_trigger_out_n = s_q.trig_n;

  assign cbus_match_flag = {s_q.flags[ubc_pkg::FLG_C1],
                            s_q.flags[ubc_pkg::FLG_C0]};
  assign ibus_match_flag = {s_q.flags[ubc_pkg::FLG_I1],
                            s_q.flags[ubc_pkg::FLG_I0]};
endmodule // user_break_unit
`default_nettype wire

/* ubc_props.sv */
// Purpose: port checks of the break unit
// Assumes: steady settings
// Notes: bound from the bench
`timescale 1ns/1ps
`default_nettype none
module ubc_props (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // settings
  input wire logic [31:0] ch0_break_address,
  input wire logic [31:0] ch0_break_address_mask_reg,
  input wire logic [15:0] ch0_bus_cycle_select_reg,
  input wire logic ch0_post_exec_select,
  input wire logic [1:0] trigger_pulse_width,
  input wire logic module_standby,
  input wire logic flag_write,
  input wire logic [3:0] flag_write_data,
  // core activity
  input wire logic exec_valid,
  input wire logic [31:0] exec_addr,
  input wire logic exec_delay_slot,
  input wire logic exec_lower_half,
  input wire logic higher_exception,
  input wire logic cbus_valid,
  input wire logic ibus_valid,
  // results
  input wire logic break_request,
  input wire logic [31:0] break_return_addr,
  input wire logic break_trigger_out_n,
  input wire logic [1:0] cbus_match_flag,
  input wire logic [1:0] ibus_match_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic hit0;
  assign hit0 = exec_valid && !module_standby && !ch0_break_address[0]
    && ch0_bus_cycle_select_reg == 16'h0054
    && ((exec_addr ^ ch0_break_address) & ~ch0_break_address_mask_reg)
    == 32'h0000_0000;
  sequence quiet_bus;
    !exec_valid && !cbus_valid && !ibus_valid;
  endsequence
  sequence trig_eight;
    !break_trigger_out_n [*7] ##1 break_trigger_out_n;
  endsequence
  AST_PRE_FETCH: assert property (
    hit0 && !ch0_post_exec_select && !exec_delay_slot && !exec_lower_half
    && !higher_exception |=> break_request
    && break_return_addr == $past(exec_addr))
    else $error("no pre break");
  AST_FLAG_SET: assert property (hit0 |=> cbus_match_flag[0])
    else $error("no flag");
  AST_LSB_BLOCK: assert property (
    ch0_bus_cycle_select_reg[5:4] == 2'h1 && ch0_break_address[0]
    && !cbus_match_flag[0] |=> !cbus_match_flag[0])
    else $error("lsb break");
  AST_STANDBY: assert property (module_standby |=> !break_request)
    else $error("standby request");
  AST_FLAG_CLR: assert property (
    flag_write && flag_write_data == 4'h0 ##0 quiet_bus
    |=> cbus_match_flag == 2'h0 && ibus_match_flag == 2'h0)
    else $error("flags kept");
  AST_TRIG_ONE: assert property (
    $fell(break_trigger_out_n) && trigger_pulse_width == 2'h0
    |=> break_trigger_out_n)
    else $error("trigger not 1");
  AST_TRIG_EIGHT: assert property (
    $fell(break_trigger_out_n) && trigger_pulse_width == 2'h3 |=> trig_eight)
    else $error("trigger not 8");
  AST_REQ_TRIG: assert property (
    break_request |-> !break_trigger_out_n)
    else $error("no trigger");
endmodule // ubc_props
`default_nettype wire

/* cpu_model.sv */
// Purpose: core side model
// Assumes: falling-edge drive, one-cycle strobes
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  // clock
  input wire logic clk,
  // instruction stream
  output var logic exec_valid,
  output var logic [31:0] exec_addr,
  output var logic exec_delay_slot,
  output var logic exec_delayed_branch,
  output var logic exec_lower_half,
  output var logic higher_exception,
  output var logic target_valid,
  output var logic [31:0] target_addr,
  // bus accesses
  output var logic cbus_valid,
  output var logic [31:0] cbus_addr,
  output var logic [31:0] cbus_data,
  output var logic cbus_write,
  output var logic [1:0] cbus_size,
  output var logic prefetch_instruction,
  output var logic ibus_valid,
  output var logic [31:0] ibus_addr,
  output var logic [31:0] ibus_data,
  output var logic ibus_write,
  output var logic [1:0] ibus_size
);
  initial begin
    {exec_valid, exec_addr, exec_delay_slot, exec_delayed_branch} = '0;
    {exec_lower_half, higher_exception, target_valid, target_addr} = '0;
    {cbus_valid, cbus_addr, cbus_data, cbus_write, cbus_size} = '0;
    {prefetch_instruction, ibus_valid, ibus_addr, ibus_data} = '0;
    {ibus_write, ibus_size} = '0;
  end
  // q = {exception, lower half, delayed branch, delay slot}
  task automatic instr(input logic [31:0] a, input logic [3:0] q);
    @(negedge clk);
    exec_valid = 1'b1;
    exec_addr = a;
    {higher_exception, exec_lower_half, exec_delayed_branch,
      exec_delay_slot} = q;
    @(negedge clk);
    exec_valid = 1'b0;
    exec_addr = ~a;
    {higher_exception, exec_lower_half, exec_delayed_branch,
      exec_delay_slot} = 4'h0;
  endtask
  task automatic tgt(input logic [31:0] a);
    @(negedge clk);
    target_valid = 1'b1;
    target_addr = a;
    @(negedge clk);
    target_valid = 1'b0;
    target_addr = ~a;
  endtask
  task automatic acc(input logic ib, input logic [31:0] a,
                     input logic [31:0] d, input logic w,
                     input logic [1:0] s, input logic p);
    @(negedge clk);
    if (ib) begin
      {ibus_valid, ibus_addr, ibus_data, ibus_write, ibus_size} =
        {1'b1, a, d, w, s};
    end else begin
      {cbus_valid, cbus_addr, cbus_write, cbus_size} = {1'b1, a, w, s};
      cbus_data = p ? ~cbus_data : d;
      prefetch_instruction = p;
    end
    @(negedge clk);
    {cbus_valid, ibus_valid, prefetch_instruction} = 3'h0;
    {cbus_addr, cbus_data} = ~{cbus_addr, cbus_data};
    {ibus_addr, ibus_data} = ~{ibus_addr, ibus_data};
  endtask
endmodule // cpu_model
`default_nettype wire

/* tb_user_break_unit.sv */
// Purpose: user break unit bench
// Assumes: core model drives cycles
// Notes: settings change between scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_user_break_unit;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] ba [2] = '{default: 32'h0};
  logic [31:0] am [2] = '{default: 32'h0};
  logic [31:0] dv [2] = '{default: 32'h0};
  logic [31:0] dk [2] = '{default: 32'h0};
  logic [15:0] bs [2] = '{default: 16'h0};
  logic [1:0] post = 2'h0;
  logic [1:0] tw = 2'h0;
  logic stby = 1'b0;
  logic fw = 1'b0;
  logic [3:0] fwd = 4'h0;
  int error_cnt = 0;
  int checked = 0;
  logic exec_valid, exec_delay_slot, exec_delayed_branch, exec_lower_half;
  logic target_valid, higher_exception, cbus_valid, cbus_write;
  logic prefetch_instruction, ibus_valid, ibus_write, break_request;
  logic break_trigger_out_n;
  logic [31:0] exec_addr, target_addr, cbus_addr, cbus_data, ibus_addr;
  logic [31:0] ibus_data, break_return_addr;
  logic [1:0] cbus_size, ibus_size, cbus_match_flag, ibus_match_flag;
  cpu_model i_cpu (.*);
  user_break_unit i_dut (.*,
    .ch0_break_address(ba[0]), .ch0_break_address_mask_reg(am[0]),
    .ch0_break_data_reg(dv[0]), .ch0_break_data_mask_reg(dk[0]),
    .ch0_bus_cycle_select_reg(bs[0]), .ch1_break_address(ba[1]),
    .ch1_break_address_mask_reg(am[1]), .ch1_break_data_reg(dv[1]),
    .ch1_break_data_mask_reg(dk[1]), .ch1_bus_cycle_select_reg(bs[1]),
    .ch0_post_exec_select(post[0]), .ch1_post_exec_select(post[1]),
    .trigger_pulse_width(tw), .module_standby(stby), .flag_write(fw),
    .flag_write_data(fwd));
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic fire(input logic r, input logic [31:0] a);
    chk({31'h0, break_request}, {31'h0, r});
    if (r) chk(break_return_addr, a);
  endtask
  task automatic cfg(input int c, input logic [31:0] a, input logic [31:0] m,
                     input logic [31:0] d, input logic [31:0] dm,
                     input logic [15:0] b);
    @(negedge clk);
    ba[c] = a;
    am[c] = m;
    dv[c] = d;
    dk[c] = dm;
    bs[c] = b;
  endtask
  task automatic clr(input logic [3:0] v);
    @(negedge clk);
    fw = 1'b1;
    fwd = v;
    @(negedge clk);
    fw = 1'b0;
  endtask
  task automatic t_pre;
    cfg(0, 32'h0000_0404, 32'h0, 32'h0, 32'h0, 16'h0054);
    i_cpu.instr(32'h0000_0406, 4'h0);
    fire(1'b0, 32'h0);
    i_cpu.instr(32'h0000_0404, 4'h0);
    fire(1'b1, 32'h0000_0404);
    chk({31'h0, break_trigger_out_n}, 32'h0);
    clr(4'hF);
    chk({30'h0, cbus_match_flag}, 32'h1);
    clr(4'h0);
  endtask
  task automatic t_post;
    post = 2'h1;
    i_cpu.instr(32'h0000_0404, 4'h0);
    fire(1'b0, 32'h0);
    i_cpu.instr(32'h0000_0406, 4'h0);
    fire(1'b1, 32'h0000_0406);
    i_cpu.instr(32'h0000_0404, 4'h2);
    i_cpu.instr(32'h0000_0406, 4'h1);
    fire(1'b0, 32'h0);
    i_cpu.tgt(32'h0000_0900);
    fire(1'b1, 32'h0000_0900);
    post = 2'h0;
    i_cpu.instr(32'h0000_0404, 4'h4);
    fire(1'b0, 32'h0);
    i_cpu.instr(32'h0000_0408, 4'h0);
    fire(1'b1, 32'h0000_0408);
    clr(4'h0);
  endtask
  task automatic t_slot;
    i_cpu.instr(32'h0000_0404, 4'h1);
    fire(1'b0, 32'h0);
    i_cpu.tgt(32'h0000_0800);
    fire(1'b1, 32'h0000_0800);
    clr(4'h0);
  endtask
  task automatic t_refuse;
    logic [15:0] sel [9];
    sel = '{16'h0054, 16'h0094, 16'h0014, 16'h0044, 16'h0050, 16'h00D4,
      16'h0054, 16'h0054, 16'h2054};
    for (int k = 0; k < 9; k++) begin
      cfg(0, {31'h0000_0202, k == 0}, 32'h0, 32'h0, 32'h0, sel[k]);
      stby = (k == 6);
      i_cpu.instr(32'h0000_0404, {k == 7, 3'h0});
      fire(1'b0, 32'h0);
      if (k == 8) chk({31'h0, break_trigger_out_n}, 32'h0);
      stby = 1'b0;
      clr(4'h0);
    end
  endtask
  task automatic t_both;
    cfg(1, 32'h0000_0400, 32'h0000_000F, 32'hFFFF_FFFF, 32'h0, 16'h1054);
    i_cpu.instr(32'h0000_0404, 4'h0);
    fire(1'b1, 32'h0000_0404);
    chk({30'h0, cbus_match_flag}, 32'h3);
    @(negedge clk);
    chk({31'h0, break_request}, 32'h0);
    clr(4'hE);
    chk({30'h0, cbus_match_flag}, 32'h2);
    clr(4'h0);
    cfg(1, 32'h0, 32'h0, 32'h0, 32'h0, 16'h0000);
  endtask
  task automatic t_trig;
    int n;
    for (int w = 0; w < 4; w++) begin
      tw = w[1:0];
      i_cpu.instr(32'h0000_0404, 4'h0);
      n = 0;
      while (break_trigger_out_n !== 1'b1 && n < 20) begin
        n++;
        @(negedge clk);
      end
      chk(n, 32'h1 << w);
      clr(4'h0);
    end
    tw = 2'h0;
  endtask
  task automatic t_size;
    logic [31:0] ad [5];
    logic [1:0] sz [5];
    logic [4:0] hit;
    ad = '{32'h0000_1000, 32'h0000_1002, 32'h0000_1003, 32'h0000_1002,
      32'h0000_1000};
    sz = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h2};
    hit = 5'h07;
    cfg(0, 32'h0000_1003, 32'h0, 32'h0, 32'h0, 16'h0064);
    for (int k = 0; k < 5; k++) begin
      i_cpu.acc(1'b0, ad[k], 32'h0, 1'b0, sz[k], 1'b0);
      chk({31'h0, cbus_match_flag[0]}, {31'h0, hit[k]});
      clr(4'h0);
    end
    i_cpu.instr(32'h0000_2000, 4'h0);
    fire(1'b1, 32'h0000_2000);
    cfg(0, 32'h0, 32'h0, 32'h0, 32'h0, 16'h0000);
  endtask
  task automatic t_value;
    cfg(1, 32'h000A_BCDE, 32'h0000_00FF, 32'hA512_A512, 32'h0, 16'h106A);
    i_cpu.acc(1'b0, 32'h000A_BC10, 32'hA512_A512, 1'b1, 2'h2, 1'b0);
    chk({30'h0, cbus_match_flag}, 32'h2);
    clr(4'h0);
    i_cpu.acc(1'b0, 32'h000A_BC10, 32'hA513_A513, 1'b1, 2'h2, 1'b0);
    chk({30'h0, cbus_match_flag}, 32'h0);
    cfg(1, 32'h0000_1000, 32'h0, 32'h0, 32'h0, 16'h1067);
    i_cpu.acc(1'b0, 32'h0000_1000, 32'h0, 1'b0, 2'h3, 1'b1);
    chk({30'h0, cbus_match_flag}, 32'h0);
    i_cpu.instr(32'h0000_3000, 4'h0);
    fire(1'b1, 32'h0000_3000);
    clr(4'h0);
  endtask
  task automatic t_ibus;
    cfg(1, 32'h0005_5555, 32'h0, 32'h7878_7878, 32'h0F0F_0F0F, 16'h11A9);
    i_cpu.acc(1'b0, 32'h0005_5555, 32'h7A7A_7A7A, 1'b1, 2'h1, 1'b0);
    chk({28'h0, ibus_match_flag, cbus_match_flag}, 32'h0);
    i_cpu.acc(1'b1, 32'h0005_5555, 32'h7A7A_7A7A, 1'b1, 2'h1, 1'b0);
    chk({28'h0, ibus_match_flag, cbus_match_flag}, 32'h8);
    i_cpu.instr(32'h0000_4000, 4'h0);
    fire(1'b1, 32'h0000_4000);
    clr(4'h0);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_pre;
    t_post;
    t_slot;
    t_refuse;
    t_both;
    t_trig;
    t_size;
    t_value;
    t_ibus;
    print_verdict;
  end
endmodule // tb_user_break_unit
bind user_break_unit ubc_props i_props (.*);
`default_nettype wire
